/* eoc_chk_assertions.sv */
// checker for the external oscillator control block
`timescale 1ns/1ps
module eoc_chk (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // bus
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  // front end
  input logic amp_ok,
  input logic osc_tick,
  input logic osc_enable_r,
  input logic crystal_sel_r,
  input logic rc_sel_r,
  input logic cap_sel_r,
  input logic ext_clk_sel_r,
  input logic div2_sel_r,
  input logic [2:0] ext_osc_drive_range_r,
  input logic [15:0] band_max_khz_r,
  // pins and clock out
  input logic port0_bit2_claim_r,
  input logic port0_bit3_claim_r,
  input logic ext_osc_tick_r,
  input logic crystal_valid_flag_r
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // properties
  sequence s_amp_lost;
    !amp_ok [*3];
  endsequence
  property p_vld_drop;
    s_amp_lost |=> !crystal_valid_flag_r;
  endproperty
  a_vld_drop: assert property (p_vld_drop) else $error("valid flag held");
  property p_vld_mode;
    crystal_valid_flag_r |-> crystal_sel_r || $past(crystal_sel_r);
  endproperty
  a_vld_mode: assert property (p_vld_mode) else $error("valid off crystal");
  property p_xband;
    crystal_sel_r && ext_osc_drive_range_r == 3'h0 |-> band_max_khz_r == 16'h0020;
  endproperty
  a_xband: assert property (p_xband) else $error("crystal band");
  property p_rband;
    rc_sel_r && ext_osc_drive_range_r == 3'h7 |-> band_max_khz_r == 16'h0c80;
  endproperty
  a_rband: assert property (p_rband) else $error("rc band");
  property p_pin2;
    port0_bit2_claim_r == crystal_sel_r;
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin2 claim");
  property p_pin3;
    port0_bit3_claim_r == osc_enable_r;
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin3 claim");
  property p_off;
    !osc_enable_r |-> !(crystal_sel_r | rc_sel_r | cap_sel_r | ext_clk_sel_r | div2_sel_r);
  endproperty
  a_off: assert property (p_off) else $error("mode when off");
  property p_div;
    rc_sel_r || cap_sel_r |-> !div2_sel_r;
  endproperty
  a_div: assert property (p_div) else $error("divide in rc");
  property p_tick;
    ext_osc_tick_r |-> $past(osc_tick);
  endproperty
  a_tick: assert property (p_tick) else $error("tick without source");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read latency");
endmodule  // eoc_chk
bind eoc_ctrl eoc_chk u_chk (.*);

/* eoc_ctrl.v */
// external oscillator control: axi4-lite register file, mode decode, pins
`timescale 1ns/1ps
`include "eoc_regs.vh"

module eoc_ctrl #(
  parameter SETTLE_CYCLES = `EOC_SETTLE_CYCLES
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analog front end
  input wire amp_ok,
  input wire osc_tick,
  output reg osc_enable_r,
  output reg crystal_sel_r,
  output reg rc_sel_r,
  output reg cap_sel_r,
  output reg ext_clk_sel_r,
  output reg div2_sel_r,
  output reg [2:0] ext_osc_drive_range_r,
  output reg [15:0] band_max_khz_r,
  // pin claims
  output reg port0_bit2_claim_r,
  output reg port0_bit3_claim_r,
  // clock out toward the system clock mux
  output reg ext_osc_tick_r,
  output reg crystal_valid_flag_r
);

  // ============================================================
  // decode helpers
  function [15:0] band_khz;
    input xtal;
    input rc;
    input [2:0] code;
    begin
      band_khz = 16'h0000;
      if (xtal) begin
        case (code)
          3'h0: band_khz = `EOC_XB0;
          3'h1: band_khz = `EOC_XB1;
          3'h2: band_khz = `EOC_XB2;
          3'h3: band_khz = `EOC_XB3;
          3'h4: band_khz = `EOC_XB4;
          3'h5: band_khz = `EOC_XB5;
          3'h6: band_khz = `EOC_XB6;
          default: band_khz = `EOC_XB7;
        endcase
      end else if (rc) begin
        case (code)
          3'h0: band_khz = `EOC_RB0;
          3'h1: band_khz = `EOC_RB1;
          3'h2: band_khz = `EOC_RB2;
          3'h3: band_khz = `EOC_RB3;
          3'h4: band_khz = `EOC_RB4;
          3'h5: band_khz = `EOC_RB5;
          3'h6: band_khz = `EOC_RB6;
          default: band_khz = `EOC_RB7;
        endcase
      end
    end
  endfunction

  function addr_is;
    input [11:0] addr;
    input [11:0] index;
    begin
      addr_is = (addr[11:2] == index[9:0]) && (addr[1:0] == 2'b00);
    end
  endfunction

  // ============================================================
  // control register
  reg [2:0] mode_r;
  reg [2:0] drive_r;
  localparam [7:0] CTRL_RST = `EOC_CTRL_RESET;
  wire is_xtal = (mode_r[2:1] == `EOC_MODE_XTAL);
  wire is_rc = (mode_r == `EOC_MODE_RC);
  wire is_cap = (mode_r == `EOC_MODE_CAP);
  wire is_ext = (mode_r[2:1] == `EOC_MODE_EXT);
  wire is_on = (mode_r != `EOC_MODE_OFF);
  wire is_div2 = (is_xtal || is_ext) && mode_r[0];
  wire settled;

  wire [7:0] ctrl_rd = {crystal_valid_flag_r, mode_r, 1'b0, drive_r};
  wire [31:0] stat_rd = {8'h00, port0_bit3_claim_r, port0_bit2_claim_r, div2_sel_r,
                         ext_clk_sel_r, cap_sel_r, rc_sel_r, crystal_sel_r,
                         osc_enable_r, band_max_khz_r};

  // ============================================================
  // write channel
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] awaddr_r;
  reg [7:0] wdata_r;
  reg wstrb0_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EOC_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      mode_r <= CTRL_RST[`EOC_MODE_HI:`EOC_MODE_LO];
      drive_r <= CTRL_RST[`EOC_DRIVE_HI:`EOC_DRIVE_LO];
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (addr_is(awaddr_r, `EOC_CTRL_INDEX)) begin
          s_axi_bresp <= `EOC_RESP_OKAY;
          // the valid bit and bit 3 ignore writes
          if (wstrb0_r) begin
            mode_r <= wdata_r[`EOC_MODE_HI:`EOC_MODE_LO];
            drive_r <= wdata_r[`EOC_DRIVE_HI:`EOC_DRIVE_LO];
          end
        end else if (addr_is(awaddr_r, `EOC_STAT_INDEX)) begin
          s_axi_bresp <= `EOC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `EOC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ============================================================
  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EOC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (addr_is(s_axi_araddr, `EOC_CTRL_INDEX)) begin
          s_axi_rdata <= {24'h00_0000, ctrl_rd};
          s_axi_rresp <= `EOC_RESP_OKAY;
        end else if (addr_is(s_axi_araddr, `EOC_STAT_INDEX)) begin
          s_axi_rdata <= stat_rd;
          s_axi_rresp <= `EOC_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `EOC_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ============================================================
  // crystal settle qualifier
  eoc_settle #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .crystal_en(is_xtal),
    .amp_ok(amp_ok),
    .valid_r(settled)
  );

  // ============================================================
  // front-end drive and pin claims
  // outputs lag the register by one cycle so every port comes from a flop
  reg half_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable_r <= 1'b0;
      crystal_sel_r <= 1'b0;
      rc_sel_r <= 1'b0;
      cap_sel_r <= 1'b0;
      ext_clk_sel_r <= 1'b0;
      div2_sel_r <= 1'b0;
      ext_osc_drive_range_r <= 3'h0;
      band_max_khz_r <= 16'h0000;
      port0_bit2_claim_r <= 1'b0;
      port0_bit3_claim_r <= 1'b0;
      crystal_valid_flag_r <= 1'b0;
      ext_osc_tick_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      osc_enable_r <= is_on;
      crystal_sel_r <= is_xtal;
      rc_sel_r <= is_rc;
      cap_sel_r <= is_cap;
      ext_clk_sel_r <= is_ext;
      div2_sel_r <= is_div2;
      // lowering drive on a running crystal does not disturb the valid flag
      ext_osc_drive_range_r <= drive_r;
      band_max_khz_r <= band_khz(is_xtal, is_rc, drive_r);
      port0_bit2_claim_r <= is_xtal;
      port0_bit3_claim_r <= is_on;
      crystal_valid_flag_r <= settled && is_xtal;
      // divide-by-2 passes every second oscillator tick
      if (!is_on) begin
        half_r <= 1'b0;
        ext_osc_tick_r <= 1'b0;
      end else if (osc_tick) begin
        half_r <= ~half_r;
        ext_osc_tick_r <= is_div2 ? half_r : 1'b1;
      end else begin
        ext_osc_tick_r <= 1'b0;
      end
    end
  end

endmodule // eoc_ctrl

/* eoc_osc_model.sv */
// far-side oscillator model: crystal, rc network or clock source
`timescale 1ns/1ps
module eoc_osc_model (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // drive circuit state and bench control
  input wire enable,
  input wire crystal,
  input wire run,
  // oscillator outputs
  output logic amp_ok,
  output logic osc_tick
);
  // ==========
  // oscillation
  logic [1:0] cnt_r;
  // no ticks while the drive circuit is off, as a real source would stall
  always @(posedge aclk) begin
    if (!aresetn || !enable)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  assign osc_tick = enable && cnt_r == 2'h3;
  // amplitude only builds with a crystal fitted and the bench letting it run
  // run also stands for pins already skipped, driven high and set analog
  assign amp_ok = run && crystal && enable;
endmodule  // eoc_osc_model

/* eoc_regs.vh */
// constants for the external oscillator control block
`ifndef EOC_REGS_VH
`define EOC_REGS_VH

// ============================================================
// register map
`define EOC_CTRL_INDEX 12'h09F
`define EOC_STAT_INDEX 12'h0A0
`define EOC_CTRL_RESET 8'h00

// ============================================================
// control field layout
`define EOC_VALID_BIT 7
`define EOC_MODE_HI 6
`define EOC_MODE_LO 4
`define EOC_DRIVE_HI 2
`define EOC_DRIVE_LO 0

// ============================================================
// mode codes
`define EOC_MODE_OFF 3'h0
`define EOC_MODE_EXT 2'h1
`define EOC_MODE_RC 3'h4
`define EOC_MODE_CAP 3'h5
`define EOC_MODE_XTAL 2'h3

// ============================================================
// band upper limits in khz, crystal column
`define EOC_XB0 16'h0020
`define EOC_XB1 16'h0054
`define EOC_XB2 16'h00E1
`define EOC_XB3 16'h024E
`define EOC_XB4 16'h05DC
`define EOC_XB5 16'h0FA0
`define EOC_XB6 16'h2710
`define EOC_XB7 16'h7530
// band upper limits in khz, rc column
`define EOC_RB0 16'h0019
`define EOC_RB1 16'h0032
`define EOC_RB2 16'h0064
`define EOC_RB3 16'h00C8
`define EOC_RB4 16'h0190
`define EOC_RB5 16'h0320
`define EOC_RB6 16'h0640
`define EOC_RB7 16'h0C80

// ============================================================
// timing
`define EOC_CLK_PERIOD_NS 5
`define EOC_SETTLE_NS 1000
`define EOC_SETTLE_CYCLES ((`EOC_SETTLE_NS + `EOC_CLK_PERIOD_NS - 1) / `EOC_CLK_PERIOD_NS)

// ============================================================
// bus answers
`define EOC_RESP_OKAY 2'h0
`define EOC_RESP_SLVERR 2'h2

`endif

/* eoc_settle.v */
// amplitude settle qualifier for the crystal valid flag
`timescale 1ns/1ps
`include "eoc_regs.vh"

module eoc_settle #(
  parameter SETTLE_CYCLES = `EOC_SETTLE_CYCLES,
  parameter CW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // qualifier
  input wire crystal_en,
  input wire amp_ok,
  output reg valid_r
);

  reg [CW-1:0] cnt_r;
  // the count is cut to the counter width on purpose
  localparam integer LAST_I = SETTLE_CYCLES - 1;
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  // ============================================================
  // counter
  // any loss of amplitude restarts the wait, so a marginal crystal never reads valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= {CW{1'b0}};
      valid_r <= 1'b0;
    end else if (!crystal_en || !amp_ok) begin
      cnt_r <= {CW{1'b0}};
      valid_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      valid_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule // eoc_settle

/* tb.sv */
// testbench for the external oscillator control block
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, amp_ok, osc_tick, run, en, xtal;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] drv;
  logic tck;
  int n_fail, total_checks, cyc, k, nt;
  typedef struct {logic [7:0] wr; logic [7:0] rd; logic [23:0] st;} eoc_row_t;
  localparam logic [11:0] CTRL = 12'h27c;
  localparam logic [11:0] STAT = 12'h280;
  // ==========
  // rows: write, readback, status
  eoc_row_t rows [9] = '{'{8'h10, 8'h10, 24'h81_0000}, '{8'h23, 8'h23, 24'h91_0000},
    '{8'h33, 8'h33, 24'hb1_0000},
    '{8'hcf, 8'h47, 24'h85_0c80}, '{8'h40, 8'h40, 24'h85_0019},
    '{8'h55, 8'h55, 24'h89_0000}, '{8'h60, 8'h60, 24'hc3_0020},
    '{8'h77, 8'h77, 24'he3_7530}, '{8'h00, 8'h00, 24'h00_0000}};
  eoc_ctrl #(.SETTLE_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .amp_ok(amp_ok), .osc_tick(osc_tick), .osc_enable_r(en), .crystal_sel_r(xtal),
    .rc_sel_r(), .cap_sel_r(), .ext_clk_sel_r(), .div2_sel_r(), .ext_osc_drive_range_r(drv),
    .band_max_khz_r(), .port0_bit2_claim_r(), .port0_bit3_claim_r(),
    .ext_osc_tick_r(tck), .crystal_valid_flag_r());
  eoc_osc_model u_osc (.aclk(aclk), .aresetn(aresetn), .enable(en), .crystal(xtal),
    .run(run), .amp_ok(amp_ok), .osc_tick(osc_tick));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // no test should need this long; a stuck handshake lands here
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test;
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // each channel lets go at the edge that takes it; only the bench timeout ends a wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic hb;
    logic [1:0] rs;
    hb = 1'b0;
    rs = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        hb = 1'b1;
        rs = bresp;
      end
    end
    bready <= 1'b0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    logic hv;
    logic [1:0] rs;
    hv = 1'b0;
    rs = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hv) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        hv = 1'b1;
        rs = rresp;
        d = rdata;
      end
    end
    rready <= 1'b0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(CTRL, {24'h0, rows[i].wr}, 2'h0);
      rd(CTRL, q, 2'h0);
      chk(q, {24'h0, rows[i].rd});
      rd(STAT, q, 2'h0);
      chk(q, {8'h0, rows[i].st});
      chk({29'h0, drv}, {29'h0, rows[i].rd[2:0]});
    end
    // unmapped, misaligned and read-only places
    wr(12'h004, 32'h0000_0070, 2'h2);
    rd(12'h004, q, 2'h2);
    chk(q, 32'h0000_0000);
    rd(12'h27d, q, 2'h2);
    wr(STAT, 32'hffff_ffff, 2'h0);
    rd(STAT, q, 2'h0);
    chk(q, 32'h0000_0000);
    // a ctrl write without its low byte lane leaves the register alone
    wstrb <= 4'he;
    wr(CTRL, 32'h0000_0060, 2'h0);
    wstrb <= 4'hf;
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_0000);
    // crystal start-up: pins already prepared, flag low until amplitude settles, then poll
    wr(CTRL, 32'h0000_0067, 2'h0);
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_0067);
    run <= 1'b1;
    repeat (4) @(posedge aclk);
    for (k = 0; k < 20 && q[7] !== 1'b1; k++) rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_00e7);
    wr(CTRL, 32'h0000_0060, 2'h0);
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_00e0);
    run <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_0060);
    // external clock: every source tick passes, or every second one with the divider
    for (int j = 0; j < 2; j++) begin
      wr(CTRL, j ? 32'h0000_0030 : 32'h0000_0020, 2'h0);
      repeat (8) @(posedge aclk);
      nt = 0;
      for (k = 0; k < 40; k++) begin
        @(posedge aclk);
        if (tck === 1'b1) nt++;
      end
      chk(nt, j ? 5 : 10);
    end
    // reset in mid-run: control and every mode output back to zero
    wr(CTRL, 32'h0000_0077, 2'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL, q, 2'h0);
    chk(q, 32'h0000_0000);
    rd(STAT, q, 2'h0);
    chk(q, 32'h0000_0000);
    finish_test;
  end
endmodule  // tb
